// ---- logic/error_flags_and_gpio_control.sv ----
// Purpose: error flag latching, combined error output and gpio pin control
// Assumes: register port already decoded from the serial frame; sensors asynchronous
// Notes:   one filter instance per analog sensor; gpio count is a parameter
`timescale 1ns/1ps

module err_filter #(
    parameter int LEN_W = 4
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             tick,
    input  wire logic [LEN_W-1:0] len,
    input  wire logic             din,
    output logic                  dout
);
    logic [LEN_W-1:0] cnt_r;

    // a zero-width length field cannot hold a delay
    if (LEN_W < 1) begin : gBadLen
        $error("filter length field needs at least one bit");
    end

    always_ff @(posedge clk) begin
        if (srst || !din) begin
            cnt_r <= '0;
        end else if (tick && cnt_r != len) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign dout = din && (cnt_r == len);
endmodule : err_filter

module error_flags_and_gpio_control
    import gpio_err_pkg::*;
#(
    parameter int NUM_GPIO = 6
) (
    input  wire logic                 clk,
    input  wire logic                 srst,
    input  wire gpio_err_pkg::reg_req_t regReq,
    output logic [7:0]                regRdData,
    input  wire gpio_err_pkg::err_sense_t errSense,
    input  wire logic                 checksumFault,
    input  wire logic                 bufTrigCmd,
    input  wire logic                 csActive,
    input  wire logic [2:0]           csIndex,
    input  wire logic [NUM_GPIO-1:0]  gpioIn,
    output logic [NUM_GPIO-1:0]       gpioOut,
    output logic [NUM_GPIO-1:0]       gpioOe_n,
    output logic                      errorOut,
    output logic                      bufferActive,
    output logic                      sync_in_a,
    output logic                      outGainMult,
    output logic [SW_W-1:0]           switchCtrl,
    output logic [7:0]                gainSetting
);
    import gpio_err_pkg::*;

    // pin roles, read-back packing and the cs decode are laid out for six pins
    if (NUM_GPIO != 6) begin : gBadGpio
        $error("pin roles are fixed for six gpio pins");
    end
    // the tick counter is five bits wide
    if (TICK_CYC < 1 || TICK_CYC > 32) begin : gBadTick
        $error("tick divider does not fit its counter");
    end
    // the buffer sub-step counter is four bits wide
    if (BUF_STEP_US < 1 || BUF_STEP_US > 16) begin : gBadStep
        $error("buffer step does not fit its counter");
    end
    // status read-back packs the flags just below the buffer bit
    if (NUM_ERR != BUFFER_ACTIVE_BIT) begin : gBadStat
        $error("status layout does not match flag count");
    end

    logic [7:0] gainMux_r, outStage_r, bufTime_r, gpioData_r, switches_r;
    logic [7:0] gpioDir_r, csMode_r, errMask_r, errCfg_r, sfRoute_r;
    logic [NUM_ERR-1:0] errFlags_r;
    logic [4:0]  tickCnt_r;
    logic        tick;
    logic        oscillator_out_r;
    logic [NUM_GPIO-1:0] pinMeta_r, pinSync_r;
    logic [4:0]  senseMeta_r, senseSync_r;
    logic [4:0]  senseFilt;
    logic [NUM_ERR-1:0] liveErr;
    logic        blank;
    logic        latchDis;
    logic        bufActive_r;
    logic [7:0]  bufCnt_r;
    logic [3:0]  bufUnit_r;
    logic        bufTrigPin_r;
    logic        bufStart;
    logic        wrHit;
    logic [NUM_GPIO-1:0] sfOut;
    logic [NUM_GPIO-1:0] sfEn;
    logic [NUM_ERR-1:0]  w1cMask;

    assign wrHit = regReq.wrEn;

    // flag bits written as one to the status register
    assign w1cMask = (wrHit && regReq.addr == REG_ERR_STATUS)
                   ? regReq.wrData[NUM_ERR-1:0] : '0;

    // one-microsecond enable for filters, buffer timer and oscillator out
    always_ff @(posedge clk) begin
        if (srst || tickCnt_r == 5'(TICK_CYC - 1)) begin
            tickCnt_r <= '0;
        end else begin
            tickCnt_r <= tickCnt_r + 5'd1;
        end
    end
    assign tick = (tickCnt_r == 5'(TICK_CYC - 1));

    always_ff @(posedge clk) begin
        if (srst) begin
            oscillator_out_r <= 1'b0;
        end else if (tick) begin
            oscillator_out_r <= ~oscillator_out_r;
        end
    end

    // configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            gainMux_r  <= RST_GAIN_MUX;
            outStage_r <= RST_OUT_STAGE;
            bufTime_r  <= RST_BUF_TIME;
            gpioData_r <= RST_GPIO_DATA;
            switches_r <= RST_SWITCHES;
            gpioDir_r  <= RST_GPIO_DIR;
            csMode_r   <= RST_CS_MODE;
            errMask_r  <= RST_ERR_MASK;
            errCfg_r   <= RST_ERR_CFG;
            sfRoute_r  <= RST_SF_ROUTE;
        end else if (wrHit) begin
            case (regReq.addr)
                REG_GAIN_MUX:  gainMux_r  <= regReq.wrData;
                REG_OUT_STAGE: outStage_r <= regReq.wrData;
                REG_BUF_TIME:  bufTime_r  <= regReq.wrData;
                REG_GPIO_DATA: gpioData_r <= regReq.wrData;
                REG_SWITCHES:  switches_r <= regReq.wrData;
                REG_GPIO_DIR:  gpioDir_r  <= regReq.wrData;
                REG_CS_MODE:   csMode_r   <= regReq.wrData;
                REG_ERR_MASK:  errMask_r  <= regReq.wrData;
                REG_ERR_CFG:   errCfg_r   <= regReq.wrData;
                REG_SF_ROUTE:  sfRoute_r  <= regReq.wrData;
                default:       ;
            endcase
        end
    end

    assign outGainMult = outStage_r[OUT_MULT_BIT];
    assign switchCtrl  = switches_r[SW_W-1:0];
    assign gainSetting = gainMux_r;

    // two-stage synchronisers for pins and sensors
    always_ff @(posedge clk) begin
        if (srst) begin
            pinMeta_r   <= '0;
            pinSync_r   <= '0;
            senseMeta_r <= '0;
            senseSync_r <= '0;
        end else begin
            pinMeta_r   <= gpioIn;
            pinSync_r   <= pinMeta_r;
            senseMeta_r <= errSense;
            senseSync_r <= senseMeta_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : gFilt
            err_filter #(.LEN_W(FILT_W)) uFilt (
                .clk  (clk),
                .srst (srst),
                .tick (tick),
                .len  (errCfg_r[FILT_LSB +: FILT_W]),
                .din  (senseSync_r[g]),
                .dout (senseFilt[g])
            );
        end
    endgenerate

    assign blank    = bufActive_r && !errCfg_r[BLANK_DIS_BIT];
    assign latchDis = errCfg_r[LATCH_DIS_BIT];

    // struct order: iov, gain, clamp, outClip, outOvercur (msb first)
    always_comb begin
        liveErr = '0;
        liveErr[ERR_IOV]   = senseFilt[4];
        liveErr[ERR_GAIN]  = senseFilt[3];
        liveErr[ERR_CLAMP] = senseFilt[2];
        liveErr[ERR_OUT]   = senseFilt[1] | senseFilt[0];
        liveErr[ERR_CHK]   = checksumFault && errCfg_r[CHK_EN_BIT];
        if (blank) begin
            liveErr = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            errFlags_r <= '0;
        end else if (latchDis) begin
            errFlags_r <= liveErr;
        end else begin
            errFlags_r <= (errFlags_r & ~w1cMask) | liveErr;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            errorOut <= 1'b0;
        end else begin
            errorOut <= |(errFlags_r & errMask_r[NUM_ERR-1:0]);
        end
    end

    // buffer trigger from the special-function pin, rising edge
    always_ff @(posedge clk) begin
        if (srst) begin
            bufTrigPin_r <= 1'b0;
        end else begin
            bufTrigPin_r <= pinSync_r[PIN_BUFT] && sfEn[PIN_BUFT];
        end
    end
    assign bufStart = bufTrigCmd || (pinSync_r[PIN_BUFT] && sfEn[PIN_BUFT] && !bufTrigPin_r);

    always_ff @(posedge clk) begin
        if (srst) begin
            bufActive_r <= 1'b0;
            bufCnt_r    <= '0;
            bufUnit_r   <= '0;
        end else if (bufStart) begin
            bufActive_r <= 1'b1;
            bufCnt_r    <= {4'h0, bufTime_r[BUFFER_TIMEOUT_LSB +: BUFFER_TIMEOUT_W]};
            bufUnit_r   <= 4'(BUF_STEP_US - 1);
        end else if (bufActive_r && tick) begin
            if (bufUnit_r != 4'h0) begin
                bufUnit_r <= bufUnit_r - 4'h1;
            end else if (bufCnt_r == 8'h00) begin
                bufActive_r <= 1'b0;
            end else begin
                bufCnt_r  <= bufCnt_r - 8'h01;
                bufUnit_r <= 4'(BUF_STEP_US - 1);
            end
        end
    end
    assign bufferActive = bufActive_r;

    // sync input only when pin 2 is routed as a special-function input
    assign sync_in_a = sfRoute_r[SF_SYNC_BIT] && sfEn[PIN_EXT_SELECT_BIT2] && pinSync_r[PIN_EXT_SELECT_BIT2];

    always_comb begin
        sfEn  = sfRoute_r[NUM_GPIO-1:0];
        sfOut = '0;
        sfOut[PIN_EXT_SELECT_BIT0] = gainMux_r[MUX_LSB];
        sfOut[PIN_EXT_SELECT_BIT1] = gainMux_r[MUX_LSB + 1];
        sfOut[PIN_EXT_SELECT_BIT2] = gainMux_r[MUX_LSB + 2];
        sfOut[PIN_EF]   = errorOut;
        sfOut[PIN_BUFFER_ACTIVE] = sfRoute_r[SF_OSC_BIT] ? oscillator_out_r : bufActive_r;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            gpioOut  <= '0;
            gpioOe_n <= '1;
        end else begin
            for (int i = 0; i < NUM_GPIO; i++) begin
                gpioOe_n[i] <= !gpioDir_r[i];
                if (sfEn[i]) begin
                    gpioOut[i] <= sfOut[i];
                end else if (csMode_r[i]) begin
                    gpioOut[i] <= !(csActive && csIndex == 3'(i));
                end else begin
                    gpioOut[i] <= gpioData_r[i];
                end
            end
        end
    end

    // register read
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdData <= 8'h00;
        end else begin
            case (regReq.addr)
                REG_GAIN_MUX:   regRdData <= gainMux_r;
                REG_OUT_STAGE:  regRdData <= outStage_r;
                REG_BUF_TIME:   regRdData <= bufTime_r;
                REG_ERR_STATUS: regRdData <= {2'b00, bufActive_r, errFlags_r};
                REG_GPIO_DATA:  regRdData <= gpioData_r;
                REG_SWITCHES:   regRdData <= switches_r;
                REG_GPIO_PINS:  regRdData <= {2'b00, pinSync_r};
                REG_GPIO_DIR:   regRdData <= gpioDir_r;
                REG_CS_MODE:    regRdData <= csMode_r;
                REG_ERR_MASK:   regRdData <= errMask_r;
                REG_ERR_CFG:    regRdData <= errCfg_r;
                REG_SF_ROUTE:   regRdData <= sfRoute_r;
                default:        regRdData <= 8'h00;
            endcase
        end
    end

endmodule : error_flags_and_gpio_control

// ---- pkg/gpio_err_pkg.sv ----
// Purpose: shared constants and types for the error flag and gpio block
// Assumes: 20 MHz core clock, 4-bit register pointer, 8-bit register data
// Notes:   offsets are register pointers on the serial register port
package gpio_err_pkg;

    // clock and time base
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUF_STEP_US   = 8;

    // register pointers
    localparam logic [3:0] REG_GAIN_MUX   = 4'h0;
    localparam logic [3:0] REG_OUT_STAGE  = 4'h1;
    localparam logic [3:0] REG_BUF_TIME   = 4'h3;
    localparam logic [3:0] REG_ERR_STATUS = 4'h4;
    localparam logic [3:0] REG_GPIO_DATA  = 4'h5;
    localparam logic [3:0] REG_SWITCHES   = 4'h6;
    localparam logic [3:0] REG_GPIO_PINS  = 4'h7;
    localparam logic [3:0] REG_GPIO_DIR   = 4'h8;
    localparam logic [3:0] REG_CS_MODE    = 4'h9;
    localparam logic [3:0] REG_ERR_MASK   = 4'ha;
    localparam logic [3:0] REG_ERR_CFG    = 4'hb;
    localparam logic [3:0] REG_SF_ROUTE   = 4'hc;

    // reset values
    localparam logic [7:0] RST_GAIN_MUX  = 8'h00;
    localparam logic [7:0] RST_OUT_STAGE = 8'h00;
    localparam logic [7:0] RST_BUF_TIME  = 8'h00;
    localparam logic [7:0] RST_GPIO_DATA = 8'h00;
    localparam logic [7:0] RST_SWITCHES  = 8'h00;
    localparam logic [7:0] RST_GPIO_DIR  = 8'h00;
    localparam logic [7:0] RST_CS_MODE   = 8'h00;
    localparam logic [7:0] RST_ERR_MASK  = 8'h1f;
    localparam logic [7:0] RST_ERR_CFG   = 8'h00;
    localparam logic [7:0] RST_SF_ROUTE  = 8'h00;

    // field positions
    localparam int MUX_LSB       = 0;
    localparam int MUX_W         = 3;
    localparam int OUT_MULT_BIT  = 0;
    localparam int BUFFER_TIMEOUT_LSB    = 0;
    localparam int BUFFER_TIMEOUT_W      = 4;
    localparam int FILT_LSB      = 0;
    localparam int FILT_W        = 4;
    localparam int LATCH_DIS_BIT = 4;
    localparam int BLANK_DIS_BIT = 5;
    localparam int CHK_EN_BIT    = 6;
    localparam int SF_OSC_BIT    = 6;
    localparam int SF_SYNC_BIT   = 7;
    localparam int SW_W          = 5;

    // error status bits
    localparam int ERR_IOV   = 0;
    localparam int ERR_GAIN  = 1;
    localparam int ERR_OUT   = 2;
    localparam int ERR_CLAMP = 3;
    localparam int ERR_CHK   = 4;
    localparam int BUFFER_ACTIVE_BIT  = 5;
    localparam int NUM_ERR   = 5;

    // gpio pin roles in special-function mode
    localparam int PIN_EXT_SELECT_BIT0 = 0;
    localparam int PIN_EXT_SELECT_BIT1 = 1;
    localparam int PIN_EXT_SELECT_BIT2 = 2;
    localparam int PIN_EF   = 3;
    localparam int PIN_BUFT = 4;
    localparam int PIN_BUFFER_ACTIVE = 5;

    typedef struct packed {
        logic       wrEn;
        logic [3:0] addr;
        logic [7:0] wrData;
    } reg_req_t;

    typedef struct packed {
        logic iov;
        logic gain;
        logic clamp;
        logic outClip;
        logic outOvercur;
    } err_sense_t;

endpackage : gpio_err_pkg

// ---- bench/error_flags_and_gpio_control_props.sv ----
// Purpose: port-level assertions for the error flag and gpio block
// Assumes: one clock, synchronous active-high reset
// Notes:   shadows the error config register to qualify some checks
`timescale 1ns/1ps
module error_flags_and_gpio_control_props #(
    parameter int NUM_GPIO = 6
) (
    input wire logic                     clk,
    input wire logic                     srst,
    input wire gpio_err_pkg::reg_req_t   regReq,
    input wire logic [7:0]               regRdData,
    input wire logic                     checksumFault,
    input wire logic                     bufTrigCmd,
    input wire logic [NUM_GPIO-1:0]      gpioOut,
    input wire logic [NUM_GPIO-1:0]      gpioOe_n,
    input wire logic                     errorOut,
    input wire logic                     bufferActive,
    input wire logic                     outGainMult,
    input wire logic [gpio_err_pkg::SW_W-1:0] switchCtrl,
    input wire logic [7:0]               gainSetting
);
    import gpio_err_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [7:0] errCfg_r;
    logic       chkSeen_r;
    always_ff @(posedge clk) begin
        if (srst)
            errCfg_r <= RST_ERR_CFG;
        else if (regReq.wrEn && regReq.addr == REG_ERR_CFG)
            errCfg_r <= regReq.wrData;
    end
    // remembers whether checksum mode was ever switched on
    always_ff @(posedge clk) begin
        if (srst)
            chkSeen_r <= 1'b0;
        else if (regReq.wrEn && regReq.addr == REG_ERR_CFG && regReq.wrData[CHK_EN_BIT])
            chkSeen_r <= 1'b1;
    end
    property p_rst_pins;
        $fell(srst) |-> (&gpioOe_n) && gpioOut == '0 && !errorOut && !bufferActive;
    endproperty
    a_rst_pins: assert property (p_rst_pins)
        else $error("pins or flags not cleared by reset");
    property p_trig_buf;
        bufTrigCmd |=> bufferActive;
    endproperty
    a_trig_buf: assert property (p_trig_buf)
        else $error("buffer not engaged after trigger");
    property p_buf_min;
        $rose(bufferActive) |-> bufferActive[*8];
    endproperty
    a_buf_min: assert property (p_buf_min)
        else $error("buffer dropped too early");
    property p_blank;
        bufferActive[*7] ##0 (!errCfg_r[BLANK_DIS_BIT] && !errorOut && !regReq.wrEn
            && !$past(checksumFault)) |=> !errorOut;
    endproperty
    a_blank: assert property (p_blank)
        else $error("error raised during buffer time");
    property p_chk_off;
        $past(regReq.addr) == REG_ERR_STATUS && !chkSeen_r |-> !regRdData[ERR_CHK];
    endproperty
    a_chk_off: assert property (p_chk_off)
        else $error("checksum flag set while checksum off");
    property p_rd_stat;
        $past(regReq.addr) == REG_ERR_STATUS
            |-> regRdData[7:5] == {2'b00, $past(bufferActive)};
    endproperty
    a_rd_stat: assert property (p_rd_stat)
        else $error("status buffer bit wrong");
    property p_gain;
        regReq.wrEn && regReq.addr == REG_GAIN_MUX |=> gainSetting == $past(regReq.wrData);
    endproperty
    a_gain: assert property (p_gain)
        else $error("gain register not updated");
    property p_mult;
        regReq.wrEn && regReq.addr == REG_OUT_STAGE
            |=> outGainMult == $past(regReq.wrData[OUT_MULT_BIT]);
    endproperty
    a_mult: assert property (p_mult)
        else $error("output multiplier not updated");
    property p_sw;
        regReq.wrEn && regReq.addr == REG_SWITCHES
            |=> switchCtrl == $past(regReq.wrData[SW_W-1:0]);
    endproperty
    a_sw: assert property (p_sw)
        else $error("switch controls not updated");
    c_buf: cover property (bufTrigCmd ##2 bufferActive);
    c_err: cover property ($rose(errorOut));
    c_end: cover property ($fell(bufferActive));
endmodule : error_flags_and_gpio_control_props

bind error_flags_and_gpio_control error_flags_and_gpio_control_props #(
    .NUM_GPIO(NUM_GPIO)
) props_u (
    .clk, .srst, .regReq, .regRdData, .checksumFault, .bufTrigCmd, .gpioOut, .gpioOe_n,
    .errorOut, .bufferActive, .outGainMult, .switchCtrl, .gainSetting
);

// ---- bench/pin_partner.sv ----
// Purpose: pin-side model of mux, chip-select devices and trigger host
// Assumes: pins carry no pull resistors
// Notes:   an undriven pin shows the inverse of its last level, except the trigger pin, which shows trigLvl
`timescale 1ns/1ps
module pin_partner (
    input  wire logic       clk,
    input  wire logic [5:0] gpioOut,
    input  wire logic [5:0] gpioOe_n,
    input  wire logic       trigLvl,
    output logic [5:0]      pins,
    output logic [2:0]      muxSel
);
    import gpio_err_pkg::*;
    logic [5:0] last_r = '0;
    always_ff @(posedge clk) begin
        last_r <= pins;
    end
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!gpioOe_n[i])
                pins[i] = gpioOut[i];
            else if (i == PIN_BUFT)
                pins[i] = trigLvl;
            else
                pins[i] = ~last_r[i];
        end
    end
    assign muxSel = pins[PIN_EXT_SELECT_BIT2:PIN_EXT_SELECT_BIT0];
endmodule : pin_partner

// ---- bench/tb.sv ----
// Purpose: directed register-level test of the error flag and gpio block
// Assumes: 20 MHz clock
// Notes:   reads wait two edges for the registered read port
`timescale 1ns/1ps
module tb;
    import gpio_err_pkg::*;
    logic       clk;
    logic       srst = 1'b1;
    reg_req_t   req = '0;
    err_sense_t sense = '0;
    logic       chkFault = 1'b0;
    logic       trig = 1'b0;
    logic       csActive = 1'b0;
    logic [2:0] csIndex = '0;
    logic       trigLvl = 1'b0;
    logic [7:0] rdData, gain;
    logic [5:0] pins, gOut, gOe_n;
    logic [4:0] sw;
    logic [2:0] muxSel;
    logic       errOut, bufAct, mult;
    int         errorCnt = 0;
    int         comparisons = 0;
    int         t0;
    logic [7:0] expSt [5] = '{8'h01, 8'h02, 8'h08, 8'h04, 8'h04};
    logic [3:0] rstAddr [6] = '{REG_GPIO_DIR, REG_ERR_MASK, REG_ERR_CFG, REG_SF_ROUTE,
                                REG_CS_MODE, 4'hd};
    logic [7:0] rstVal [6] = '{RST_GPIO_DIR, RST_ERR_MASK, RST_ERR_CFG, RST_SF_ROUTE,
                               RST_CS_MODE, 8'h00};
    error_flags_and_gpio_control #(.NUM_GPIO(6)) dut_u (
        .clk, .srst, .regReq(req), .regRdData(rdData), .errSense(sense),
        .checksumFault(chkFault), .bufTrigCmd(trig), .csActive, .csIndex, .gpioIn(pins),
        .gpioOut(gOut), .gpioOe_n(gOe_n), .errorOut(errOut), .bufferActive(bufAct),
        .sync_in_a(), .outGainMult(mult), .switchCtrl(sw), .gainSetting(gain)
    );
    pin_partner partner_u (.clk, .gpioOut(gOut), .gpioOe_n(gOe_n), .trigLvl, .pins, .muxSel);
    task automatic testDone();
        $display("comparisons %0d errors %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : testDone
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{wrEn: 1'b1, addr: a, wrData: d};
        @(posedge clk);
        req.wrEn <= 1'b0;
    endtask : wr
    task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        req.addr <= a;
        cyc(2);
        chk(n, rdData, e);
    endtask : rc
    task automatic waitBuf(input logic v, input int lim);
        int k;
        k = 0;
        while (bufAct !== v && k < lim) begin
            cyc(1);
            k++;
        end
        chk("bufWait", bufAct, v);
        if (k == lim)
            testDone();
    endtask : waitBuf
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        cyc(1);
        chk("oeRst", gOe_n, 8'h3f);
        for (int i = 0; i < 6; i++)
            rc("rstReg", rstAddr[i], rstVal[i]);
        wr(REG_SWITCHES, 8'h15);
        wr(REG_OUT_STAGE, 8'h01);
        wr(REG_GAIN_MUX, 8'h05);
        cyc(1);
        chk("switch", sw, 8'h15);
        chk("mult", mult, 8'h01);
        chk("gain", gain, 8'h05);
        for (int k = 0; k < 5; k++) begin
            @(posedge clk) sense <= err_sense_t'(5'h10 >> k);
            repeat (8) @(posedge clk);
            sense <= '0;
            rc("flag", REG_ERR_STATUS, expSt[k]);
            chk("errOut", errOut, 8'h01);
            wr(REG_ERR_STATUS, 8'h00);
            rc("keep", REG_ERR_STATUS, expSt[k]);
            wr(REG_ERR_STATUS, expSt[k]);
            rc("clear", REG_ERR_STATUS, 8'h00);
            chk("errOff", errOut, 8'h00);
        end
        wr(REG_ERR_CFG, 8'h10);
        @(posedge clk) sense.iov <= 1'b1;
        repeat (6) @(posedge clk);
        rc("liveOn", REG_ERR_STATUS, 8'h01);
        @(posedge clk) sense.iov <= 1'b0;
        repeat (6) @(posedge clk);
        rc("liveOff", REG_ERR_STATUS, 8'h00);
        wr(REG_ERR_CFG, 8'h02);
        @(posedge clk) sense.iov <= 1'b1;
        repeat (10) @(posedge clk);
        sense.iov <= 1'b0;
        repeat (6) @(posedge clk);
        rc("short", REG_ERR_STATUS, 8'h00);
        @(posedge clk) sense.iov <= 1'b1;
        repeat (5 * TICK_CYC) @(posedge clk);
        rc("long", REG_ERR_STATUS, 8'h01);
        @(posedge clk) sense.iov <= 1'b0;
        repeat (4) @(posedge clk);
        wr(REG_ERR_STATUS, 8'h01);
        for (int e = 0; e < 2; e++) begin
            wr(REG_ERR_CFG, e ? 8'h40 : 8'h00);
            @(posedge clk) chkFault <= 1'b1;
            @(posedge clk) chkFault <= 1'b0;
            rc("chkFlag", REG_ERR_STATUS, e ? 8'h10 : 8'h00);
        end
        wr(REG_ERR_STATUS, 8'h10);
        wr(REG_BUF_TIME, 8'h00);
        @(posedge clk) trig <= 1'b1;
        t0 = int'($time);
        @(posedge clk) trig <= 1'b0;
        @(posedge clk) sense.iov <= 1'b1;
        #1 chk("bufAct", bufAct, 8'h01);
        repeat (20) @(posedge clk);
        sense.iov <= 1'b0;
        rc("blank", REG_ERR_STATUS, 8'h20);
        waitBuf(1'b0, 400);
        chk("bufLen", ((int'($time) - t0) / CLK_PERIOD_NS) inside
            {[(BUF_STEP_US - 1) * TICK_CYC:(BUF_STEP_US + 2) * TICK_CYC]}, 8'h01);
        rc("bufOff", REG_ERR_STATUS, 8'h00);
        wr(REG_SF_ROUTE, 8'h10);
        @(posedge clk) trigLvl <= 1'b1;
        waitBuf(1'b1, 8);
        @(posedge clk) trigLvl <= 1'b0;
        waitBuf(1'b0, 400);
        wr(REG_SF_ROUTE, 8'h00);
        wr(REG_GPIO_DIR, 8'h3f);
        wr(REG_GPIO_DATA, 8'h2a);
        cyc(2);
        chk("oeOut", gOe_n, 8'h00);
        chk("pins", pins, 8'h2a);
        wr(REG_SF_ROUTE, 8'h0f);
        cyc(2);
        chk("mux", muxSel, 8'h05);
        chk("efIdle", pins[PIN_EF], 8'h00);
        @(posedge clk) sense.gain <= 1'b1;
        cyc(8);
        chk("efSet", pins[PIN_EF], 8'h01);
        @(posedge clk) sense.gain <= 1'b0;
        repeat (4) @(posedge clk);
        wr(REG_ERR_STATUS, 8'h02);
        wr(REG_SF_ROUTE, 8'h00);
        wr(REG_GPIO_DATA, 8'h00);
        wr(REG_CS_MODE, 8'h02);
        @(posedge clk) csActive <= 1'b1;
        csIndex <= 3'd1;
        cyc(2);
        chk("csOn", pins[1:0], 8'h00);
        @(posedge clk) csActive <= 1'b0;
        cyc(2);
        chk("csOff", pins[1:0], 8'h02);
        @(posedge clk) sense.iov <= 1'b1;
        repeat (6) @(posedge clk);
        sense.iov <= 1'b0;
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        cyc(1);
        chk("oeRst2", gOe_n, 8'h3f);
        chk("multRst", mult, 8'h00);
        rc("flagRst", REG_ERR_STATUS, 8'h00);
        testDone();
    end
endmodule : tb
